// ===== rtl/sync_dynamic_termination_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module sync_dynamic_termination_ctrl #(
    parameter int HIST_DEPTH = 64
) (
    input  wire logic          aclk,          // system clock
    input  wire logic          aresetn,       // sync reset, low active
    input  wire logic [7:0]    s_axi_awaddr,  // write address
    input  wire logic          s_axi_awvalid, // write address valid
    output logic               s_axi_awready, // write address ready
    input  wire logic [31:0]   s_axi_wdata,   // write data
    input  wire logic [3:0]    s_axi_wstrb,   // byte enables
    input  wire logic          s_axi_wvalid,  // write data valid
    output logic               s_axi_wready,  // write data ready
    output logic [1:0]         s_axi_bresp,   // write response
    output logic               s_axi_bvalid,  // write response valid
    input  wire logic          s_axi_bready,  // write response ready
    input  wire logic [7:0]    s_axi_araddr,  // read address
    input  wire logic          s_axi_arvalid, // read address valid
    output logic               s_axi_arready, // read address ready
    output logic [31:0]        s_axi_rdata,   // read data
    output logic [1:0]         s_axi_rresp,   // read response
    output logic               s_axi_rvalid,  // read data valid
    input  wire logic          s_axi_rready,  // read data ready
    input  wire logic          link_ck,       // memory clock pin, sampled
    input  wire odt_pkg::pins_t pins,         // odt, write, chop pins
    input  wire logic          self_refresh,  // device in self-refresh
    input  wire logic          dll_locked,    // dll on and locked
    input  wire logic          dq_driving,    // read drivers active
    output logic               term_en,       // termination switch on
    output logic               write_sel,     // write strength selected
    output logic [2:0]         rtt_code       // strength code in use
);

    if (HIST_DEPTH < 64 - 2 || HIST_DEPTH > 64) begin : g_depth_check
        $error("HIST_DEPTH must lie in 62..64 to cover the 6-bit latency");
    end

    typedef struct packed {
        odt_pkg::pins_t            s1;
        odt_pkg::pins_t            s2;
        logic                      ck1;
        logic                      ck2;
        logic                      ck_prev;
        logic [HIST_DEPTH-1:0]     odt_h;
        logic [HIST_DEPTH-1:0]     wr_h;
        logic [HIST_DEPTH-1:0]     chop_h;
        logic [3:0]                cnt;
        logic                      off_pend;
        logic                      wr_pend;
        logic                      back_pend;
        logic                      term_on;
        logic                      wr_sel;
        logic                      term_out;
        logic [2:0]                code;
        logic [31:0]               ctrl;
        logic                      aw_have;
        logic                      w_have;
        logic [7:0]                awaddr;
        logic [31:0]               wdata;
        logic [3:0]                wstrb;
        logic                      bvalid;
        logic [1:0]                bresp;
        logic                      rvalid;
        logic [31:0]               rdata;
        logic [1:0]                rresp;
    } state_t;

    state_t state_reg;
    state_t state_next;

    function automatic logic [1:0] decode(input logic [7:0] addr);
        // 0: unmapped, 1: control, 2: status
        if (addr == odt_pkg::ADDR_CTRL)
            return 2'h1;
        else if (addr == odt_pkg::ADDR_STATUS)
            return 2'h2;
        return 2'h0;
    endfunction

    logic [2:0]  nom_code;
    logic [1:0]  wr_code;
    logic [5:0]  lat;
    logic [5:0]  lat_sum;
    logic        enabled;
    logic        dynamic;
    logic        sync_mode;
    logic        ck_rise;
    logic        ck_fall;
    logic        chop_now;
    logic [31:0] status_word;

    always_comb begin
        nom_code = state_reg.ctrl[odt_pkg::NOM_LSB +: 3];
        wr_code  = state_reg.ctrl[odt_pkg::WR_LSB +: 2];
        enabled  = (nom_code != 3'h0) || (wr_code != 2'h0);
        dynamic  = wr_code != 2'h0;
        // latency is write_cas + additive - 2, at least 1; additive shifts ODT as well
        lat_sum  = 6'(state_reg.ctrl[odt_pkg::CWL_LSB +: 5])
                 + 6'(state_reg.ctrl[odt_pkg::AL_LSB +: 5]);
        lat      = (lat_sum > odt_pkg::LAT_OFFSET) ? lat_sum - odt_pkg::LAT_OFFSET
                                                   : odt_pkg::LAT_MIN;
        sync_mode = dll_locked && !self_refresh;
        ck_rise   = state_reg.ck2 && !state_reg.ck_prev;
        ck_fall   = !state_reg.ck2 && state_reg.ck_prev;
        status_word = 32'h0;
        status_word[odt_pkg::ST_TERM]             = state_reg.term_out;
        status_word[odt_pkg::ST_WRSEL]            = state_reg.wr_sel;
        status_word[odt_pkg::ST_ENA]              = enabled;
        status_word[odt_pkg::ST_DYN]              = dynamic;
        status_word[odt_pkg::ST_CODE_LSB +: 3]    = state_reg.code;
        chop_now = 1'b0;

        state_next = state_reg;
        // two-flop synchronisers for the link clock and its pins
        state_next.ck1     = link_ck;
        state_next.ck2     = state_reg.ck1;
        state_next.ck_prev = state_reg.ck2;
        state_next.s1      = pins;
        state_next.s2      = state_reg.s1;

        if (ck_rise) begin
            state_next.odt_h  = {state_reg.odt_h[HIST_DEPTH-2:0], state_reg.s2.odt};
            state_next.wr_h   = {state_reg.wr_h[HIST_DEPTH-2:0], state_reg.s2.wr};
            state_next.chop_h = {state_reg.chop_h[HIST_DEPTH-2:0], state_reg.s2.chop};
            // index lat holds the sample taken lat edges ago
            if (state_next.odt_h[lat]) begin
                state_next.term_on  = 1'b1;
                state_next.off_pend = 1'b0;
            end else if (state_reg.term_on) begin
                state_next.off_pend = 1'b1;
            end
            if (state_next.wr_h[lat]) begin
                chop_now = state_reg.ctrl[odt_pkg::OTF_BIT] ? state_next.chop_h[lat]
                                                            : state_reg.ctrl[odt_pkg::CHOP_BIT];
                state_next.wr_pend   = 1'b1;
                state_next.back_pend = 1'b0;
                state_next.cnt = chop_now ? odt_pkg::HOLD_SHORT : odt_pkg::HOLD_LONG;
            end else if (state_reg.cnt != 4'h0) begin
                state_next.cnt = state_reg.cnt - 4'h1;
                if (state_reg.cnt == 4'h1)
                    state_next.back_pend = 1'b1;
            end
        end

        // off and strength changes land on the following falling edge
        if (ck_fall) begin
            if (state_reg.off_pend) begin
                state_next.term_on  = 1'b0;
                state_next.off_pend = 1'b0;
            end
            if (state_reg.wr_pend) begin
                state_next.wr_sel  = dynamic;
                state_next.wr_pend = 1'b0;
            end
            if (state_reg.back_pend) begin
                state_next.wr_sel    = 1'b0;
                state_next.back_pend = 1'b0;
            end
        end

        if (!sync_mode || !enabled) begin
            state_next.term_on  = 1'b0;
            state_next.off_pend = 1'b0;
        end
        if (!dynamic) begin
            state_next.wr_sel  = 1'b0;
            state_next.wr_pend = 1'b0;
        end
        // termination and output drivers must never fight on the bus
        state_next.term_out = state_next.term_on && !dq_driving;
        state_next.code     = state_next.wr_sel ? {1'b0, wr_code} : nom_code;

        // register bus: address and data taken in either order
        if (s_axi_awvalid && s_axi_awready) begin
            state_next.aw_have = 1'b1;
            state_next.awaddr  = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            state_next.w_have = 1'b1;
            state_next.wdata  = s_axi_wdata;
            state_next.wstrb  = s_axi_wstrb;
        end
        if (state_reg.aw_have && state_reg.w_have) begin
            state_next.aw_have = 1'b0;
            state_next.w_have  = 1'b0;
            state_next.bvalid  = 1'b1;
            state_next.bresp   = odt_pkg::RESP_OKAY;
            unique case (decode(state_reg.awaddr))
                2'h1: begin
                    for (int b = 0; b < 4; b++) begin
                        if (state_reg.wstrb[b])
                            state_next.ctrl[b*8 +: 8] = state_reg.wdata[b*8 +: 8]
                                                      & odt_pkg::CTRL_MASK[b*8 +: 8];
                    end
                end
                2'h2: state_next.bresp = odt_pkg::RESP_OKAY; // status is read-only
                default: state_next.bresp = odt_pkg::RESP_SLVERR;
            endcase
        end
        if (state_reg.bvalid && s_axi_bready)
            state_next.bvalid = 1'b0;

        if (s_axi_arvalid && s_axi_arready) begin
            state_next.rvalid = 1'b1;
            state_next.rresp  = odt_pkg::RESP_OKAY;
            unique case (decode(s_axi_araddr))
                2'h1: state_next.rdata = state_reg.ctrl;
                2'h2: state_next.rdata = status_word;
                default: begin
                    state_next.rdata = 32'h0;
                    state_next.rresp = odt_pkg::RESP_SLVERR;
                end
            endcase
        end else if (state_reg.rvalid && s_axi_rready) begin
            state_next.rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg      <= '0;
            state_reg.ctrl <= odt_pkg::CTRL_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // one write in flight: ready drops until the response is taken
    assign s_axi_awready = !state_reg.aw_have && !state_reg.bvalid;
    assign s_axi_wready  = !state_reg.w_have && !state_reg.bvalid;
    assign s_axi_bvalid  = state_reg.bvalid;
    assign s_axi_bresp   = state_reg.bresp;
    assign s_axi_arready = !state_reg.rvalid;
    assign s_axi_rvalid  = state_reg.rvalid;
    assign s_axi_rdata   = state_reg.rdata;
    assign s_axi_rresp   = state_reg.rresp;
    assign term_en       = state_reg.term_out;
    assign write_sel     = state_reg.wr_sel;
    assign rtt_code      = state_reg.code;

endmodule // sync_dynamic_termination_ctrl
`default_nettype wire

// ===== rtl/odt_pkg.sv
`default_nettype none
package odt_pkg;

    // register map, byte addresses on the 32-bit bus
    localparam logic [7:0]  ADDR_CTRL   = 8'h00;
    localparam logic [7:0]  ADDR_STATUS = 8'h04;

    // control register fields
    localparam int          NOM_LSB     = 0;   // mode_reg_one A9,A6,A2 as [2:0]
    localparam int          WR_LSB      = 3;   // mode_reg_two A10,A9 as [4:3]
    localparam int          AL_LSB      = 8;   // additive_latency, 5 bits
    localparam int          CWL_LSB     = 16;  // write_cas_latency, 5 bits
    localparam int          CHOP_BIT    = 24;  // fixed burst: 1 = chop_four
    localparam int          OTF_BIT     = 25;  // on_the_fly_select allowed
    localparam logic [31:0] CTRL_RESET  = 32'h0005_0000; // cwl 5, al 0, no termination
    localparam logic [31:0] CTRL_MASK   = 32'h031F_1F1F;

    // status register fields
    localparam int          ST_TERM     = 0;
    localparam int          ST_WRSEL    = 1;
    localparam int          ST_ENA      = 2;
    localparam int          ST_DYN      = 3;
    localparam int          ST_CODE_LSB = 4;

    // latency arithmetic, in link clock cycles
    localparam logic [5:0]  LAT_OFFSET  = 6'h02;
    localparam logic [5:0]  LAT_MIN     = 6'h01;
    localparam logic [3:0]  HOLD_SHORT  = 4'h4;  // chop_four
    localparam logic [3:0]  HOLD_LONG   = 4'h6;  // burst_eight

    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic odt;   // termination request pin
        logic wr;    // write command registered
        logic chop;  // on-the-fly chop_four with the write
    } pins_t;

endpackage
`default_nettype wire

// ===== bench/odt_ctrl_sva.sv
`timescale 1ns/1ps
`default_nettype none
module odt_ctrl_sva #(
    parameter int HIST_DEPTH = 64
) (
    input wire logic       aclk,          // clock
    input wire logic       aresetn,       // reset
    input wire logic       s_axi_awready, // aw ready
    input wire logic       s_axi_wready,  // w ready
    input wire logic [1:0] s_axi_bresp,   // b resp
    input wire logic       s_axi_bvalid,  // b valid
    input wire logic       s_axi_bready,  // b ready
    input wire logic       s_axi_arready, // ar ready
    input wire logic       s_axi_rvalid,  // r valid
    input wire logic       s_axi_rready,  // r ready
    input wire logic       self_refresh,  // self-refresh
    input wire logic       dll_locked,    // dll lock
    input wire logic       dq_driving,    // read drive
    input wire logic       term_en,       // termination
    input wire logic       write_sel,     // write strength
    input wire logic [2:0] rtt_code       // code in use
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_sr_off; self_refresh |=> !term_en; endproperty
    a_sr_off: assert property (p_sr_off) else $error("term on in self refresh");
    property p_dll_off; !dll_locked |=> !term_en; endproperty
    a_dll_off: assert property (p_dll_off) else $error("term on without dll");
    property p_dq_off; dq_driving |=> !term_en; endproperty
    a_dq_off: assert property (p_dq_off) else $error("term on while driving");
    property p_wr_code; write_sel |-> !rtt_code[2] && rtt_code != 3'h0; endproperty
    a_wr_code: assert property (p_wr_code) else $error("bad write code");
    property p_on_cause;
        $rose(term_en) |-> $past(dll_locked) && !$past(self_refresh) && !$past(dq_driving);
    endproperty
    a_on_cause: assert property (p_on_cause) else $error("term rose while barred");
    property p_b_block; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
    a_b_block: assert property (p_b_block) else $error("write taken during response");
    property p_r_block; s_axi_rvalid |-> !s_axi_arready; endproperty
    a_r_block: assert property (p_r_block) else $error("read taken during response");
    property p_b_done; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
    a_b_done: assert property (p_b_done) else $error("bvalid stuck");
    property p_r_done; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
    a_r_done: assert property (p_r_done) else $error("rvalid stuck");
    c_term: cover property ($rose(term_en));
    c_wsel: cover property ($rose(write_sel));
    c_err: cover property (s_axi_bvalid && s_axi_bresp == odt_pkg::RESP_SLVERR);
endmodule // odt_ctrl_sva
bind sync_dynamic_termination_ctrl odt_ctrl_sva #(.HIST_DEPTH(HIST_DEPTH)) u_sva (
    .aclk, .aresetn, .s_axi_awready, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .self_refresh,
    .dll_locked, .dq_driving, .term_en, .write_sel, .rtt_code);
`default_nettype wire

// ===== bench/mem_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module mem_ctrl_model (
    input  wire logic           aclk,    // bench clock
    output var  logic           link_ck, // memory clock
    output var  odt_pkg::pins_t pins     // odt, write, chop
);
    initial begin
        link_ck = 1'h0;
        pins = '0;
        #3;
        forever #32 link_ck = ~link_ck;
    end
    // pins move mid-cycle so every rise samples a settled level
    task automatic play(input logic [23:0] odt, input logic [23:0] wr, input logic [23:0] ch);
        for (int i = 0; i < 24; i++) begin
            @(negedge link_ck);
            @(posedge aclk);
            pins <= '{odt: odt[i], wr: wr[i], chop: wr[i] & ch[i]};
        end
        @(negedge link_ck);
        @(posedge aclk);
        pins <= '0;
    endtask
endmodule // mem_ctrl_model
`default_nettype wire

// ===== bench/sync_dynamic_termination_ctrl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module sync_dynamic_termination_ctrl_tb_top;
    logic           aclk = 1'h0;
    logic           aresetn = 1'h0;
    logic [7:0]     s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [31:0]    s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]     s_axi_wstrb = 4'hF;
    logic           s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic           s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic           s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]     s_axi_bresp, s_axi_rresp;
    logic           link_ck, term_en, write_sel;
    logic           self_refresh = 1'h0, dll_locked = 1'h1, dq_driving = 1'h0;
    logic [2:0]     rtt_code;
    odt_pkg::pins_t pins;
    int             err_total = 0;
    int             check_count = 0;
    int             kill [7] = '{0, 0, 0, 0, 1, 2, 3};
    logic [31:0]    ctl [7] = '{32'h0205_0011, 32'h0105_020A, 32'h0005_0000, 32'h0205_0001,
                                32'h0205_0011, 32'h0205_0001, 32'h0205_0011};
    always #4 aclk = ~aclk;
    sync_dynamic_termination_ctrl #(.HIST_DEPTH(64)) DUT (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .link_ck, .pins, .self_refresh,
        .dll_locked, .dq_driving, .term_en, .write_sel, .rtt_code);
    mem_ctrl_model u_ctrl (.aclk, .link_ck, .pins);
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [1:0] er);
        logic aw_t, w_t, ar_t, done;
        logic [1:0] resp;
        logic [31:0] got;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= wr;
        s_axi_wvalid <= wr;
        s_axi_bready <= wr;
        s_axi_arvalid <= !wr;
        s_axi_rready <= !wr;
        do begin
            @(negedge aclk);
            aw_t = s_axi_awvalid & s_axi_awready;
            w_t = s_axi_wvalid & s_axi_wready;
            ar_t = s_axi_arvalid & s_axi_arready;
            done = wr ? s_axi_bvalid : s_axi_rvalid;
            resp = wr ? s_axi_bresp : s_axi_rresp;
            got = s_axi_rdata;
            @(posedge aclk);
            if (aw_t) s_axi_awvalid <= 1'h0;
            if (w_t) s_axi_wvalid <= 1'h0;
            if (ar_t) s_axi_arvalid <= 1'h0;
        end while (done !== 1'h1);
        s_axi_bready <= 1'h0;
        s_axi_rready <= 1'h0;
        chk("resp", {30'h0, er}, {30'h0, resp});
        if (!wr) chk("rdata", d, got);
    endtask
    task automatic run(input int s);
        logic [31:0] c;
        logic [31:0] st;
        logic [23:0] od, wv, cv;
        logic ton, ws;
        int lat, n;
        c = ctl[s];
        od = (s == 1) ? 24'h00003C : 24'h0003FF;
        wv = (s == 1) ? 24'h000004 : 24'h00000A;
        cv = (s == 1) ? 24'h000000 : 24'h000002;
        axi(1'h1, odt_pkg::ADDR_CTRL, c, odt_pkg::RESP_OKAY);
        // idle link: termination and write strength off, nominal code shown
        st = {25'h0, c[2:0], c[4:3] != 2'h0, c[4:0] != 5'h0, 2'h0};
        axi(1'h0, odt_pkg::ADDR_STATUS, st, odt_pkg::RESP_OKAY);
        self_refresh <= (kill[s] == 1);
        dll_locked <= (kill[s] != 2);
        dq_driving <= (kill[s] == 3);
        lat = int'(c[20:16]) + int'(c[12:8]) - 2;
        fork
            u_ctrl.play(od, wv, cv);
            for (int j = 0; j < 24; j++) begin
                // align once with the model, then one look per link rise
                if (j == 0) @(negedge link_ck);
                @(posedge link_ck);
                #44;
                ton = (j >= lat && od[j-lat]) || (j > lat && od[j-lat-1]);
                ton = ton && c[4:0] != 5'h0 && kill[s] == 0;
                ws = 1'h0;
                for (int k = 0; k < j - lat; k++)
                    if (wv[k]) begin
                        n = (c[24] | (c[25] & cv[k])) ? 4 : 6;
                        ws = c[4:3] != 2'h0 && j <= k + lat + n;
                    end
                chk("term_en", 32'(ton), 32'(term_en));
                if (kill[s] == 0)
                    chk("write_sel", 32'(ws), 32'(write_sel));
                if (ton)
                    chk("rtt_code", ws ? 32'(c[4:3]) : 32'(c[2:0]), 32'(rtt_code));
            end
        join
        $display("test %0d done", s);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        #300000;
        err_total++;
        report_and_stop();
    end
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'h1;
        axi(1'h0, odt_pkg::ADDR_CTRL, odt_pkg::CTRL_RESET, odt_pkg::RESP_OKAY);
        axi(1'h0, odt_pkg::ADDR_STATUS, 32'h0, odt_pkg::RESP_OKAY);
        axi(1'h0, 8'h08, 32'h0, odt_pkg::RESP_SLVERR);
        axi(1'h1, 8'h08, 32'h0, odt_pkg::RESP_SLVERR);
        axi(1'h1, odt_pkg::ADDR_STATUS, 32'hFFFF_FFFF, odt_pkg::RESP_OKAY);
        axi(1'h0, odt_pkg::ADDR_STATUS, 32'h0, odt_pkg::RESP_OKAY);
        axi(1'h1, odt_pkg::ADDR_CTRL, 32'hFFFF_FFFF, odt_pkg::RESP_OKAY);
        axi(1'h0, odt_pkg::ADDR_CTRL, odt_pkg::CTRL_MASK, odt_pkg::RESP_OKAY);
        $display("register test done");
        for (int s = 0; s < 7; s++) run(s);
        report_and_stop();
    end
endmodule // sync_dynamic_termination_ctrl_tb_top
`default_nettype wire
